// ==== logic/cerr_pkg.sv ====
// Contract
// - Status bits clear only by writing one
// - Status at 110h, resets to zero
// - Bit 13 sets on advisory non-fatal error
// - Bit 12 sets on replay timer expiry
// - Bit 8 sets on replay count rollover
// - Bit 7 sets on symbol error in DLLP
// - Bit 6 sets on symbol error in TLP
// - Bit 0 sets on any symbol error
// - Unimplemented bits read zero, ignore writes
// - Masked error does not set status bit
// - Masked error sends no error message
// - Masked error skips header log, first pointer
// - Mask at 114h, resets to 0000 2000h
// - Mask bits 12,8,7,6,0 read/write, reset zero
// - Link, global, power-on resets clear both registers
`default_nettype none

package cerr_pkg;

  // Configuration access geometry
  localparam int          ADDR_W      = 12;      // Extended config space byte address
  localparam int          DATA_W      = 32;      // One dword per register
  localparam int          BE_W        = 4;       // One enable per byte lane
  localparam int          PTR_W       = 5;       // Bit index within a dword

  // Register offsets
  localparam logic [11:0] STATUS_OFS  = 12'h110; // Correctable error status
  localparam logic [11:0] MASK_OFS    = 12'h114; // Correctable error mask

  // Field positions shared by status and mask
  localparam int          BIT_ADVISORY = 13;     // Advisory non-fatal
  localparam int          BIT_RETRY    = 12;     // Replay timer expiry
  localparam int          BIT_ROLLOVER = 8;      // Replay count rollover
  localparam int          BIT_LINK_PKT = 7;      // Symbol error inside DLLP
  localparam int          BIT_TXN_PKT  = 6;      // Symbol error inside TLP
  localparam int          BIT_SYMBOL   = 0;      // Any symbol error

  // Implemented bits (13,12,8,7,6,0); the rest are hardwired zero
  localparam logic [31:0] IMPL_BITS    = 32'h0000_31c1;

  // Reset values
  localparam logic [31:0] STATUS_RST   = 32'h0000_0000;
  localparam logic [31:0] MASK_RST     = 32'h0000_2000;

  // Reset pin filter depth
  localparam int          SYNC_DEPTH   = 3;

endpackage : cerr_pkg

`default_nettype wire

// ==== logic/cerr_evt_if.sv ====
`timescale 1ns/100ps
`default_nettype none

// Carries raw error events and the mask into the gate, and the gated results back
interface cerr_evt_if;

  logic [31:0] raw_evt;   // Error events, one per status position
  logic [31:0] mask;      // Current mask register contents
  logic [31:0] gated;     // Events that survive the mask
  logic        any_hit;   // At least one unmasked event this cycle
  logic [4:0]  first_idx; // Highest-priority unmasked event position

  // Register core drives events and mask
  modport core (
    output raw_evt,
    output mask,
    input  gated,
    input  any_hit,
    input  first_idx
  );

  // Gate computes the masked view
  modport gate (
    input  raw_evt,
    input  mask,
    output gated,
    output any_hit,
    output first_idx
  );

endinterface : cerr_evt_if

`default_nettype wire

// ==== logic/cerr_event_gate.sv ====
`timescale 1ns/100ps
`default_nettype none

// Applies the mask to each event and picks the lowest unmasked position
module cerr_event_gate (
  cerr_evt_if.gate evt
);

  logic [31:0] gated_w; // Per-bit masked events

  // One gate per bit; unimplemented positions never pass
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_bit
      assign gated_w[g] = evt.raw_evt[g] & ~evt.mask[g] & cerr_pkg::IMPL_BITS[g];
    end
  endgenerate

  assign evt.gated   = gated_w;
  assign evt.any_hit = |gated_w;

  // Lowest set position wins; scanning downward lets lower bits overwrite
  always_comb begin
    evt.first_idx = '0;
    for (int i = 31; i >= 0; i--) begin
      if (gated_w[i]) begin
        evt.first_idx = i[4:0];
      end
    end
  end

endmodule : cerr_event_gate

`default_nettype wire

// ==== logic/cerr_regs.sv ====
`timescale 1ns/100ps
`default_nettype none

// Correctable error status and mask register pair
module cerr_regs (
  input  wire logic        I_MCLK,                            // Core clock, 250 MHz
  input  wire logic        I_RESETN,                          // Power-on reset, async, active low
  input  wire logic        I_FUNDAMENTAL_LINK_RESET_N,        // Link reset pin, active low
  input  wire logic        I_GLOBAL_RESET_INPUT_N,            // Global reset pin, active low
  input  wire logic        I_CFG_REQ,                         // Config access strobe, one cycle
  input  wire logic        I_CFG_WR,                          // 1 = write, 0 = read
  input  wire logic [11:0] I_CFG_ADDR,                        // Byte address in extended space
  input  wire logic [3:0]  I_CFG_BE,                          // Byte enables for writes
  input  wire logic [31:0] I_CFG_WDATA,                       // Write data
  input  wire logic        I_ADVISORY_NONFATAL_SEEN,          // Advisory non-fatal error pulse
  input  wire logic        I_RETRY_TIMER_EXPIRED,             // Replay timer expiry pulse
  input  wire logic        I_REPLAY_ROLLOVER,                 // Replay count rollover pulse
  input  wire logic        I_LINK_PACKET_DECODE_FAULT,        // Symbol error during DLLP
  input  wire logic        I_TRANSACTION_PACKET_DECODE_FAULT, // Symbol error during TLP
  input  wire logic        I_SYMBOL_DECODE_FAULT,             // Symbol error at any time
  output logic             O_CFG_ACK,                         // Access answered
  output logic             O_CFG_HIT,                         // Access matched a register
  output logic [31:0]      O_CFG_RDATA,                       // Read data
  output logic             O_COR_MSG_REQ,                     // Send correctable error message
  output logic             O_HDR_LOG_LOAD,                    // Load header log
  output logic             O_FIRST_ERR_UPDATE,                // Update first error pointer
  output logic [4:0]       O_FIRST_ERR_PTR,                   // Pointer value to load
  output logic             O_COR_PENDING                      // Any status bit set
);

  // ---------------------------------------------------------------------
  // Reset pin filters
  // ---------------------------------------------------------------------

  logic [2:0] link_sync_r;  // Link reset pin shift chain
  logic [2:0] glob_sync_r;  // Global reset pin shift chain
  logic       link_rst_n_r; // Filtered link reset level
  logic       glob_rst_n_r; // Filtered global reset level
  logic       link_rst_n_nxt;
  logic       glob_rst_n_nxt;

  // Three stages; first stage only feeds the second, so metastability stays contained
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      link_sync_r <= '1;
      glob_sync_r <= '1;
    end else begin
      link_sync_r <= {link_sync_r[1:0], I_FUNDAMENTAL_LINK_RESET_N};
      glob_sync_r <= {glob_sync_r[1:0], I_GLOBAL_RESET_INPUT_N};
    end
  end

  // A change is accepted only when stages two and three agree
  assign link_rst_n_nxt = (link_sync_r[1] == link_sync_r[2]) ? link_sync_r[2] : link_rst_n_r;
  assign glob_rst_n_nxt = (glob_sync_r[1] == glob_sync_r[2]) ? glob_sync_r[2] : glob_rst_n_r;

  // Filtered levels, idle high out of power-on reset
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      link_rst_n_r <= 1'b1;
      glob_rst_n_r <= 1'b1;
    end else begin
      link_rst_n_r <= link_rst_n_nxt;
      glob_rst_n_r <= glob_rst_n_nxt;
    end
  end

  // Either pin reset clears the registers synchronously; power-on clears them asynchronously.
  // Hot reset or function-level resets are not routed here on purpose.
  wire pin_reset = ~link_rst_n_r | ~glob_rst_n_r;

  // ---------------------------------------------------------------------
  // Configuration access decode
  // ---------------------------------------------------------------------

  wire hit_status = (I_CFG_ADDR == cerr_pkg::STATUS_OFS);
  wire hit_mask   = (I_CFG_ADDR == cerr_pkg::MASK_OFS);
  wire hit_any    = hit_status | hit_mask;
  wire wr_cycle   = I_CFG_REQ & I_CFG_WR;
  wire rd_cycle   = I_CFG_REQ & ~I_CFG_WR;

  // Byte enables widened to a bit mask
  logic [31:0] be_bits;
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_be
      assign be_bits[8*b +: 8] = {8{I_CFG_BE[b]}};
    end
  endgenerate

  // Bits written with one under an enabled lane; writing zero to status does nothing
  wire [31:0] wr_ones    = I_CFG_WDATA & be_bits;
  wire [31:0] clear_bits = (wr_cycle & hit_status) ? (wr_ones & cerr_pkg::IMPL_BITS) : '0;
  wire [31:0] mask_we    = (wr_cycle & hit_mask) ? (be_bits & cerr_pkg::IMPL_BITS) : '0;

  // ---------------------------------------------------------------------
  // Error event collection
  // ---------------------------------------------------------------------

  logic [31:0] status_r; // Correctable error status
  logic [31:0] mask_r;   // Correctable error mask
  logic [31:0] raw_evt;  // Events placed at their status positions

  // Detectors are on this clock, so no synchroniser is used
  always_comb begin
    raw_evt                         = '0;
    raw_evt[cerr_pkg::BIT_ADVISORY] = I_ADVISORY_NONFATAL_SEEN;
    raw_evt[cerr_pkg::BIT_RETRY]    = I_RETRY_TIMER_EXPIRED;
    raw_evt[cerr_pkg::BIT_ROLLOVER] = I_REPLAY_ROLLOVER;
    raw_evt[cerr_pkg::BIT_LINK_PKT] = I_LINK_PACKET_DECODE_FAULT;
    raw_evt[cerr_pkg::BIT_TXN_PKT]  = I_TRANSACTION_PACKET_DECODE_FAULT;
    // A symbol error inside a packet is still a symbol error, so bit 0 also takes both
    raw_evt[cerr_pkg::BIT_SYMBOL]   = I_SYMBOL_DECODE_FAULT
                                    | I_LINK_PACKET_DECODE_FAULT
                                    | I_TRANSACTION_PACKET_DECODE_FAULT;
  end

  // Gate shares the mask with the event path
  cerr_evt_if evt ();

  assign evt.raw_evt = raw_evt;
  assign evt.mask    = mask_r;

  cerr_event_gate u_gate (
    .evt (evt)
  );

  // ---------------------------------------------------------------------
  // Status and mask storage, one flop per implemented bit
  // ---------------------------------------------------------------------

  logic [31:0] status_nxt;
  logic [31:0] mask_nxt;

  genvar k;
  generate
    for (k = 0; k < 32; k++) begin : g_reg
      if (cerr_pkg::IMPL_BITS[k]) begin : g_impl
        // Set term wins over a clear in the same cycle
        assign status_nxt[k] = evt.gated[k] | (status_r[k] & ~clear_bits[k]);
        // Mask bit loads only under its own byte enable
        assign mask_nxt[k]   = mask_we[k] ? I_CFG_WDATA[k] : mask_r[k];

        // Status flop
        always_ff @(posedge I_MCLK or negedge I_RESETN) begin
          if (!I_RESETN) begin
            status_r[k] <= cerr_pkg::STATUS_RST[k];
          end else if (pin_reset) begin
            status_r[k] <= cerr_pkg::STATUS_RST[k];
          end else begin
            status_r[k] <= status_nxt[k];
          end
        end

        // Mask flop
        always_ff @(posedge I_MCLK or negedge I_RESETN) begin
          if (!I_RESETN) begin
            mask_r[k] <= cerr_pkg::MASK_RST[k];
          end else if (pin_reset) begin
            mask_r[k] <= cerr_pkg::MASK_RST[k];
          end else begin
            mask_r[k] <= mask_nxt[k];
          end
        end
      end else begin : g_rsvd
        // Reserved position: no storage, reads zero
        assign status_nxt[k] = 1'b0;
        assign mask_nxt[k]   = 1'b0;
        assign status_r[k]   = 1'b0;
        assign mask_r[k]     = 1'b0;
      end
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Read response
  // ---------------------------------------------------------------------

  logic [31:0] rd_sel;    // Value chosen for a read
  logic [31:0] rdata_r;   // Registered read data
  logic        ack_r;     // Registered acknowledge
  logic        hit_r;     // Registered address match

  // Unmapped addresses read as zero and report no hit
  always_comb begin
    if (hit_status) begin
      rd_sel = status_r;
    end else if (hit_mask) begin
      rd_sel = mask_r;
    end else begin
      rd_sel = '0;
    end
  end

  // Answer lands one cycle after the strobe; a read returns the pre-edge state
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ack_r   <= 1'b0;
      hit_r   <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r   <= I_CFG_REQ;
      hit_r   <= I_CFG_REQ & hit_any;
      rdata_r <= rd_cycle ? rd_sel : '0;
    end
  end

  assign O_CFG_ACK   = ack_r;
  assign O_CFG_HIT   = hit_r;
  assign O_CFG_RDATA = rdata_r;

  // ---------------------------------------------------------------------
  // Reporting pulses
  // ---------------------------------------------------------------------

  logic       msg_r;   // Message request
  logic       log_r;   // Header log load
  logic       ptr_upd_r; // First pointer update
  logic [4:0] ptr_r;   // Pointer value

  // Only unmasked events report; a pin reset suppresses reporting too
  wire report = evt.any_hit & ~pin_reset;

  // Unmasked events in one cycle yield one message; the message layer merges duplicates
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      msg_r     <= 1'b0;
      log_r     <= 1'b0;
      ptr_upd_r <= 1'b0;
      ptr_r     <= '0;
    end else begin
      msg_r     <= report;
      log_r     <= report;
      ptr_upd_r <= report;
      ptr_r     <= report ? evt.first_idx : ptr_r;
    end
  end

  assign O_COR_MSG_REQ      = msg_r;
  assign O_HDR_LOG_LOAD     = log_r;
  assign O_FIRST_ERR_UPDATE = ptr_upd_r;
  assign O_FIRST_ERR_PTR    = ptr_r;

  // Pending view follows the stored status directly
  assign O_COR_PENDING = |status_r;

endmodule : cerr_regs

`default_nettype wire

// ==== bench/cerr_regs_properties.sv ====
`timescale 1ns/100ps
`default_nettype none

// Pin-level watch of the error register pair
module cerr_regs_properties (
  input wire logic        I_MCLK,
  input wire logic        I_RESETN,
  input wire logic        I_CFG_REQ,
  input wire logic [11:0] I_CFG_ADDR,
  input wire logic        I_ADVISORY_NONFATAL_SEEN,
  input wire logic        I_RETRY_TIMER_EXPIRED,
  input wire logic        I_REPLAY_ROLLOVER,
  input wire logic        I_LINK_PACKET_DECODE_FAULT,
  input wire logic        I_TRANSACTION_PACKET_DECODE_FAULT,
  input wire logic        I_SYMBOL_DECODE_FAULT,
  input wire logic        O_CFG_ACK,
  input wire logic        O_CFG_HIT,
  input wire logic [31:0] O_CFG_RDATA,
  input wire logic        O_COR_MSG_REQ,
  input wire logic        O_HDR_LOG_LOAD,
  input wire logic        O_FIRST_ERR_UPDATE,
  input wire logic [4:0]  O_FIRST_ERR_PTR,
  input wire logic        O_COR_PENDING
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RESETN);

  // Address names one of the two registers
  wire logic map_w = (I_CFG_ADDR == cerr_pkg::STATUS_OFS) || (I_CFG_ADDR == cerr_pkg::MASK_OFS);
  // Any detector fired this cycle
  wire logic evt_w = I_ADVISORY_NONFATAL_SEEN | I_RETRY_TIMER_EXPIRED | I_REPLAY_ROLLOVER |
                     I_LINK_PACKET_DECODE_FAULT | I_TRANSACTION_PACKET_DECODE_FAULT | I_SYMBOL_DECODE_FAULT;

  chk_ack_after_req: assert property (I_CFG_REQ |=> O_CFG_ACK)
    else $error("no answer after request");
  chk_hit_decode: assert property (I_CFG_REQ |=> O_CFG_HIT == $past(map_w))
    else $error("hit flag wrong for address");
  chk_unmapped_zero: assert property (I_CFG_REQ && !map_w |=> O_CFG_RDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_rsvd_read_zero: assert property ((O_CFG_RDATA & ~cerr_pkg::IMPL_BITS) == 32'h0)
    else $error("reserved read bit set");
  chk_msg_has_cause: assert property (O_COR_MSG_REQ |-> $past(evt_w))
    else $error("message without event");
  chk_pulses_agree: assert property (O_COR_MSG_REQ == O_HDR_LOG_LOAD && O_HDR_LOG_LOAD == O_FIRST_ERR_UPDATE)
    else $error("report pulses disagree");
  chk_ptr_legal: assert property (O_FIRST_ERR_UPDATE |-> cerr_pkg::IMPL_BITS[O_FIRST_ERR_PTR])
    else $error("pointer names no error");
  chk_report_sets: assert property (O_COR_MSG_REQ |-> O_COR_PENDING)
    else $error("report without status");
endmodule : cerr_regs_properties

bind cerr_regs cerr_regs_properties u_props (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_CFG_REQ(I_CFG_REQ),
  .I_CFG_ADDR(I_CFG_ADDR), .I_ADVISORY_NONFATAL_SEEN(I_ADVISORY_NONFATAL_SEEN),
  .I_RETRY_TIMER_EXPIRED(I_RETRY_TIMER_EXPIRED), .I_REPLAY_ROLLOVER(I_REPLAY_ROLLOVER),
  .I_LINK_PACKET_DECODE_FAULT(I_LINK_PACKET_DECODE_FAULT),
  .I_TRANSACTION_PACKET_DECODE_FAULT(I_TRANSACTION_PACKET_DECODE_FAULT),
  .I_SYMBOL_DECODE_FAULT(I_SYMBOL_DECODE_FAULT), .O_CFG_ACK(O_CFG_ACK), .O_CFG_HIT(O_CFG_HIT),
  .O_CFG_RDATA(O_CFG_RDATA), .O_COR_MSG_REQ(O_COR_MSG_REQ), .O_HDR_LOG_LOAD(O_HDR_LOG_LOAD),
  .O_FIRST_ERR_UPDATE(O_FIRST_ERR_UPDATE), .O_FIRST_ERR_PTR(O_FIRST_ERR_PTR), .O_COR_PENDING(O_COR_PENDING));

`default_nettype wire

// ==== bench/cerr_err_src.sv ====
`timescale 1ns/100ps
`default_nettype none

// Link and physical layer error detectors, one line per error kind
module cerr_err_src (
  input  wire logic       i_clk,
  output logic      [5:0] o_evt // {advisory, retry, rollover, link pkt, txn pkt, symbol}
);
  // Detectors drive their lines low when idle
  initial o_evt = 6'h00;

  // One-cycle burst, launched just after an edge
  task automatic fire(input logic [5:0] v);
    @(posedge i_clk);
    #1 o_evt = v;
    @(posedge i_clk);
    #1 o_evt = 6'h00;
  endtask : fire
endmodule : cerr_err_src

`default_nettype wire

// ==== bench/correctable_error_status_mask_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

// Self-checking bench for the correctable error register pair
module correctable_error_status_mask_tb_top;
  logic        mclk, resetn, link_n, glob_n; // Clock and the three resets
  logic        req, wr, ack, hit, msg, log_ld, upd, pend;
  logic [11:0] addr;
  logic [3:0]  be;
  logic [31:0] wdata, rdata, rd_s;
  logic [4:0]  ptr;
  logic [5:0]  evt;
  int          bad_count, total_checks, cyc;
  localparam logic [11:0] ST = cerr_pkg::STATUS_OFS;
  localparam logic [11:0] MK = cerr_pkg::MASK_OFS;

  cerr_regs DUT (.I_MCLK(mclk), .I_RESETN(resetn), .I_FUNDAMENTAL_LINK_RESET_N(link_n),
    .I_GLOBAL_RESET_INPUT_N(glob_n), .I_CFG_REQ(req), .I_CFG_WR(wr), .I_CFG_ADDR(addr), .I_CFG_BE(be),
    .I_CFG_WDATA(wdata), .I_ADVISORY_NONFATAL_SEEN(evt[5]), .I_RETRY_TIMER_EXPIRED(evt[4]),
    .I_REPLAY_ROLLOVER(evt[3]), .I_LINK_PACKET_DECODE_FAULT(evt[2]),
    .I_TRANSACTION_PACKET_DECODE_FAULT(evt[1]), .I_SYMBOL_DECODE_FAULT(evt[0]), .O_CFG_ACK(ack),
    .O_CFG_HIT(hit), .O_CFG_RDATA(rdata), .O_COR_MSG_REQ(msg), .O_HDR_LOG_LOAD(log_ld),
    .O_FIRST_ERR_UPDATE(upd), .O_FIRST_ERR_PTR(ptr), .O_COR_PENDING(pend));
  cerr_err_src src (.i_clk(mclk), .o_evt(evt));

  // 250 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Hang guard; the full run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One access: strobe for one cycle, answer one cycle later
  task automatic cfg(input logic w, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge mclk);
    #1 {req, wr, addr, be, wdata} = {1'b1, w, a, b, d};
    @(posedge mclk);
    #1 req = 1'b0;
    check("ack", 32'h1, 32'(ack));
    rd_s = rdata;
  endtask : cfg

  task automatic wrt(input logic [11:0] a, input logic [31:0] d);
    cfg(1'b1, a, 4'hf, d);
  endtask : wrt

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    cfg(1'b0, a, 4'h0, 32'h0);
    check("hit", 32'h1, 32'(hit));
    check(what, exp, rd_s);
  endtask : rd

  // Fire events, judge the report pulses, then the status
  task automatic ev(input logic [5:0] v, input logic m, input logic [4:0] p, input logic [31:0] st);
    src.fire(v);
    check("report", 32'(m), 32'(msg));
    check("pending", 32'(st != 32'h0), 32'(pend));
    check("log load", 32'(m), 32'(log_ld));
    check("ptr update", 32'(m), 32'(upd));
    if (m) begin
      check("ptr", 32'(p), 32'(ptr));
    end
    rd(ST, st, "status");
  endtask : ev

  task automatic t_defaults;
    rd(ST, cerr_pkg::STATUS_RST, "status rst");
    rd(MK, cerr_pkg::MASK_RST, "mask rst");
    cfg(1'b0, 12'h118, 4'h0, 32'h0);
    check("unmapped hit", 32'h0, 32'(hit));
    $display("t_defaults done");
  endtask : t_defaults

  task automatic t_sources;
    logic [31:0] st_tab [6];
    logic [4:0]  pt_tab [6];
    st_tab = '{32'h1, 32'h41, 32'h81, 32'h100, 32'h1000, 32'h2000};
    pt_tab = '{5'h0, 5'h0, 5'h0, 5'h8, 5'hc, 5'hd};
    wrt(MK, 32'h0);
    for (int i = 0; i < 6; i++) begin
      ev(6'(1 << i), 1'b1, pt_tab[i], st_tab[i]);
      wrt(ST, 32'hffffffff);
      rd(ST, 32'h0, "cleared");
    end
    $display("t_sources done");
  endtask : t_sources

  task automatic t_mask;
    wrt(MK, 32'hffffffff);
    rd(MK, cerr_pkg::IMPL_BITS, "mask rw");
    ev(6'h3f, 1'b0, 5'h0, 32'h0);
    wrt(MK, 32'h21c1);
    ev(6'h3f, 1'b1, 5'hc, 32'h1000);
    wrt(ST, 32'hffffffff);
    $display("t_mask done");
  endtask : t_mask

  // Zero writes, lane enables, and a set racing a clear
  task automatic t_w1c;
    wrt(MK, 32'h0);
    ev(6'h3f, 1'b1, 5'h0, cerr_pkg::IMPL_BITS);
    wrt(ST, 32'h0);
    rd(ST, cerr_pkg::IMPL_BITS, "zero write");
    cfg(1'b1, ST, 4'h2, 32'hffffffff);
    rd(ST, 32'hc1, "lane clear");
    fork
      src.fire(6'h01);
      wrt(ST, 32'hffffffff);
    join
    rd(ST, 32'h1, "set wins");
    $display("t_w1c done");
  endtask : t_w1c

  // Each reset pin alone restores both registers
  task automatic t_pins;
    for (int p = 0; p < 2; p++) begin
      wrt(MK, 32'h0);
      src.fire(6'h3f);
      @(posedge mclk);
      #1 {link_n, glob_n} = {p != 0, p == 0};
      repeat (4) @(posedge mclk);
      #1 {link_n, glob_n} = 2'h3;
      repeat (5) @(posedge mclk);
      rd(ST, 32'h0, "pin status");
      rd(MK, cerr_pkg::MASK_RST, "pin mask");
    end
    $display("t_pins done");
  endtask : t_pins

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // Power-on reset for four cycles, then the scenarios
  initial begin
    {resetn, link_n, glob_n, req, wr, addr, be, wdata} = {3'h3, 2'h0, 12'h0, 4'h0, 32'h0};
    repeat (4) @(posedge mclk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge mclk);
    t_defaults();
    t_sources();
    t_mask();
    t_w1c();
    t_pins();
    end_sim();
  end
endmodule : correctable_error_status_mask_tb_top

`default_nettype wire
